// file: ccw_pkg.sv
// constants and types for the control link watchdog and local i2c timing block
`default_nettype none
package ccw_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_NOMINAL_MHZ = 25;
  // register offsets
  localparam logic [7:0] LINK_WDOG_OFS = 8'h07;
  localparam logic [7:0] IN_CTRL_OFS = 8'h08;
  localparam logic [7:0] OUT_CTRL_OFS = 8'h09;
  // reset values
  localparam logic [7:0] LINK_WDOG_RST = 8'hfe;
  localparam logic [7:0] IN_CTRL_RST = 8'h1c;
  localparam logic [7:0] OUT_CTRL_RST = 8'h10;
  // field positions
  localparam int TMO_LSB = 1;
  localparam int TMO_OFF_BIT = 0;
  localparam int LOCK_BIT = 7;
  localparam int HOLD_LSB = 4;
  localparam int FILT_LSB = 0;
  localparam int SETUP_LSB = 4;
  localparam int DLY_LSB = 2;
  localparam int FAST_BIT = 1;
  localparam int BUS_OFF_BIT = 0;
  // times and derived cycle counts
  localparam int TMO_UNIT_MS = 2;
  localparam int TMO_UNIT_CYC = TMO_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FILT_STEP_NS = 5;
  localparam int HOLD_STEP_NS = 50;
  localparam int SETUP_BASE_NS = 80;
  localparam int SETUP_STEP_NS = 640;
  localparam int DLY_BASE_NS = 240;
  localparam int DLY_STEP_NS = 40;
  localparam int BUS_SLOW_MS = 1000;
  localparam int BUS_SLOW_CYC = BUS_SLOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUS_FAST_US = 50;
  localparam int BUS_FAST_CYC = BUS_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int REC_HALF_NS = 5000;
  localparam int REC_HALF_CYC = REC_HALF_NS / CLK_PERIOD_NS;
  localparam int REC_PULSES = 9;

  typedef enum logic [0:0] {
    CCW_BUS_WATCH = 1'b0,
    CCW_BUS_RECOVER = 1'b1
  } ccw_bus_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccw_reg_req_s;

  // least-time conversion: round nanoseconds up to whole clock cycles
  function automatic logic [7:0] ns_to_cyc(input int ns);
    ns_to_cyc = 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
endpackage
`default_nettype wire

// file: ccw_top.sv
// control link watchdog, remote write lock and local i2c timing and bus watchdog
`default_nettype none
module ccw_top
  import ccw_pkg::*;
#(
  parameter int TMO_UNIT = TMO_UNIT_CYC,
  parameter int BUS_SLOW = BUS_SLOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire ccw_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_refused,
  // control link transaction tracking
  input wire logic link_start,
  input wire logic link_done,
  output logic link_busy,
  output logic link_abort,
  // slave data and phase from the local i2c engine
  input wire logic tx_sda_low,
  input wire logic ack_slot,
  input wire logic remote_active,
  // local i2c pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // conditioned bus view
  output logic scl_clean,
  output logic sda_clean,
  output logic bus_free,
  output logic bus_recovering
);
  typedef struct packed {
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    logic scl_f, sda_f;
    logic [3:0] scl_fc, sda_fc;
    logic [7:0] sda_line;
    logic sda_h;
    logic [7:0] r_wdog, r_in, r_out;
    logic [7:0] rdata;
    logic rvalid, refused;
    logic cc_run;
    logic [15:0] cc_pre;
    logic [6:0] cc_units;
    logic cc_abort;
    logic [23:0] idle;
    logic free;
    ccw_bus_e bst;
    logic [7:0] rec_cnt;
    logic [4:0] rec_half;
    logic rec_low;
    logic [7:0] dly;
    logic dly_run;
    logic [7:0] stretch;
    logic scl_oe, sda_oe;
  } ccw_state_s;

  ccw_state_s st, next_st;

  logic [7:0] filt_cyc, hold_cyc, setup_cyc, dly_cyc;
  logic [6:0] tmo;
  logic [23:0] bus_limit;
  logic scl_fall, activity;

  always_comb begin
    // one sample beyond the widest glitch, since a glitch may still land on one sample
    filt_cyc = ns_to_cyc(int'(st.r_in[FILT_LSB +: 4]) * FILT_STEP_NS + CLK_PERIOD_NS);
    hold_cyc = ns_to_cyc(int'(st.r_in[HOLD_LSB +: 3]) * HOLD_STEP_NS);
    setup_cyc = ns_to_cyc(SETUP_BASE_NS + int'(st.r_out[SETUP_LSB +: 4]) * SETUP_STEP_NS);
    dly_cyc = ns_to_cyc(DLY_BASE_NS + int'(st.r_out[DLY_LSB +: 2]) * DLY_STEP_NS);
    tmo = st.r_wdog[TMO_LSB +: 7];
    bus_limit = st.r_out[FAST_BIT] ? 24'(BUS_FAST_CYC) : 24'(BUS_SLOW);
  end

  always_comb begin
    next_st = st;
    // two-flop synchronisers; only the second stage feeds logic
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    // glitch filter: a new level must persist for the filter depth
    if (st.scl_s2 == st.scl_f) begin
      next_st.scl_fc = 4'h0;
    end else if (8'(st.scl_fc) + 8'h01 >= filt_cyc) begin
      next_st.scl_f = st.scl_s2;
      next_st.scl_fc = 4'h0;
    end else begin
      next_st.scl_fc = st.scl_fc + 4'h1;
    end
    if (st.sda_s2 == st.sda_f) begin
      next_st.sda_fc = 4'h0;
    end else if (8'(st.sda_fc) + 8'h01 >= filt_cyc) begin
      next_st.sda_f = st.sda_s2;
      next_st.sda_fc = 4'h0;
    end else begin
      next_st.sda_fc = st.sda_fc + 4'h1;
    end
    // sda hold: delayed copy of filtered sda so it changes after scl
    next_st.sda_line = {st.sda_line[6:0], st.sda_f};
    if (hold_cyc == 8'h00) begin
      next_st.sda_h = st.sda_f;
    end else begin
      next_st.sda_h = st.sda_line[3'(hold_cyc - 8'h01)];
    end
    scl_fall = st.scl_f && !next_st.scl_f;
    activity = (next_st.scl_f != st.scl_f) || (next_st.sda_f != st.sda_f);

    // register port; reads of unmapped offsets return zero
    next_st.rvalid = 1'b0;
    next_st.refused = 1'b0;
    if (reg_req.valid && !reg_req.write) begin
      next_st.rvalid = 1'b1;
      case (reg_req.addr)
        LINK_WDOG_OFS: next_st.rdata = st.r_wdog;
        IN_CTRL_OFS: next_st.rdata = st.r_in;
        OUT_CTRL_OFS: next_st.rdata = st.r_out;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // remote writes also arrive at this port, flagged remote, and are refused while the lock bit is set
    if (reg_req.valid && reg_req.write) begin
      if (reg_req.remote && st.r_in[LOCK_BIT]) begin
        next_st.refused = 1'b1;
      end else begin
        case (reg_req.addr)
          LINK_WDOG_OFS: next_st.r_wdog = reg_req.wdata;
          IN_CTRL_OFS: next_st.r_in = reg_req.wdata;
          OUT_CTRL_OFS: next_st.r_out = reg_req.wdata;
          default: ;
        endcase
      end
    end

    // control link watchdog; a zero timeout aborts after one unit
    next_st.cc_abort = 1'b0;
    if (link_start) begin
      next_st.cc_run = 1'b1;
      next_st.cc_pre = 16'h0000;
      next_st.cc_units = 7'h00;
    end else if (link_done) begin
      next_st.cc_run = 1'b0;
    end else if (st.cc_run && !st.r_wdog[TMO_OFF_BIT]) begin
      if (32'(st.cc_pre) + 32'h1 >= 32'(TMO_UNIT)) begin
        next_st.cc_pre = 16'h0000;
        next_st.cc_units = st.cc_units + 7'h01;
        if (st.cc_units + 7'h01 >= tmo) begin
          next_st.cc_abort = 1'b1;
          next_st.cc_run = 1'b0;
        end
      end else begin
        next_st.cc_pre = st.cc_pre + 16'h0001;
      end
    end

    // count down first so that a fresh stretch load below wins
    if (st.stretch != 8'h00) begin
      next_st.stretch = st.stretch - 8'h01;
    end
    // sda output: applied a set delay after scl falls
    if (scl_fall) begin
      next_st.dly = dly_cyc;
      next_st.dly_run = 1'b1;
    end else if (st.dly_run) begin
      next_st.dly = st.dly - 8'h01;
      if (st.dly == 8'h01) begin
        next_st.dly_run = 1'b0;
        next_st.sda_oe = tx_sda_low;
        // stretch scl low so the ack bit leads the rising edge
        if (ack_slot && remote_active) begin
          next_st.stretch = setup_cyc;
        end
      end
    end

    // bus idle watchdog and recovery
    case (st.bst)
      CCW_BUS_WATCH: begin
        if (st.r_out[BUS_OFF_BIT]) begin
          next_st.idle = 24'h000000;
        end else if (activity) begin
          next_st.idle = 24'h000000;
          next_st.free = 1'b0;
        end else if (st.idle + 24'h000001 >= bus_limit) begin
          next_st.idle = 24'h000000;
          if (st.sda_f) begin
            next_st.free = 1'b1;
          end else begin
            next_st.bst = CCW_BUS_RECOVER;
            next_st.rec_cnt = 8'(REC_HALF_CYC);
            next_st.rec_half = 5'h00;
            next_st.rec_low = 1'b1;
          end
        end else begin
          next_st.idle = st.idle + 24'h000001;
        end
      end
      CCW_BUS_RECOVER: begin
        // slow pulses so any slave can follow regardless of filter setting
        if (st.rec_cnt == 8'h01) begin
          next_st.rec_cnt = 8'(REC_HALF_CYC);
          next_st.rec_low = !st.rec_low;
          next_st.rec_half = st.rec_half + 5'h01;
          if (st.rec_half + 5'h01 == 5'(2 * REC_PULSES)) begin
            next_st.bst = CCW_BUS_WATCH;
            next_st.rec_low = 1'b0;
          end
        end else begin
          next_st.rec_cnt = st.rec_cnt - 8'h01;
        end
      end
      default: next_st.bst = CCW_BUS_WATCH;
    endcase
    next_st.scl_oe = (next_st.bst == CCW_BUS_RECOVER && next_st.rec_low) ||
                     (next_st.stretch != 8'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.scl_f <= 1'b1;
      st.sda_f <= 1'b1;
      st.sda_line <= 8'hff;
      st.sda_h <= 1'b1;
      st.r_wdog <= LINK_WDOG_RST;
      st.r_in <= IN_CTRL_RST;
      st.r_out <= OUT_CTRL_RST;
      st.bst <= CCW_BUS_WATCH;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign reg_refused = st.refused;
  assign link_busy = st.cc_run;
  assign link_abort = st.cc_abort;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = st.scl_oe;
  assign sda_oe = st.sda_oe;
  assign scl_clean = st.scl_f;
  assign sda_clean = st.sda_h;
  assign bus_free = st.free;
  assign bus_recovering = st.bst == CCW_BUS_RECOVER;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ABORT_ONLY_RUNNING: assert property (
    link_abort |-> $past(st.cc_run) && !st.cc_run)
    else $error("abort without a running transaction");
  AST_OFF_NO_ABORT: assert property (
    st.r_wdog[TMO_OFF_BIT] && $past(st.r_wdog[TMO_OFF_BIT]) |-> !link_abort)
    else $error("abort while the link watchdog is off");
  AST_START_RESTARTS: assert property (
    link_start |=> st.cc_run && st.cc_units == 7'h00 && st.cc_pre == 16'h0000)
    else $error("transaction start did not restart the watchdog");
  AST_DONE_STOPS: assert property (
    link_done && !link_start |=> !st.cc_run ##1 !link_abort)
    else $error("watchdog kept running after completion");
  AST_LOCK_REFUSES: assert property (
    reg_req.valid && reg_req.write && reg_req.remote && st.r_in[LOCK_BIT]
    |=> reg_refused && $stable(st.r_wdog) && $stable(st.r_out) && $stable(st.r_in))
    else $error("locked remote write was not refused");
  AST_LOCAL_WRITE: assert property (
    reg_req.valid && reg_req.write && !reg_req.remote && reg_req.addr == OUT_CTRL_OFS
    |=> st.r_out == $past(reg_req.wdata) && !reg_refused)
    else $error("local write did not land");
  AST_BUS_OFF_IDLE: assert property (
    st.r_out[BUS_OFF_BIT] |=> st.idle == 24'h000000 && $stable(st.free))
    else $error("bus watchdog counted while disabled");
  AST_FREE_NEEDS_HIGH: assert property (
    $rose(bus_free) |-> $past(st.sda_f))
    else $error("bus marked free with sda low");
  AST_RECOVER_LOW_SDA: assert property (
    $rose(bus_recovering) |-> !$past(st.sda_f) && scl_oe)
    else $error("recovery started without sda held low");
  AST_SCL_FILTER: assert property (
    $changed(st.scl_f) && $past(st.r_in[FILT_LSB +: 4]) != 4'h0
    |-> $past(st.scl_s2, 2) == st.scl_f)
    else $error("scl level passed the glitch filter on one sample");
  AST_SDA_FILTER: assert property (
    $changed(st.sda_f) && $past(st.r_in[FILT_LSB +: 4]) != 4'h0
    |-> $past(st.sda_s2, 2) == st.sda_f)
    else $error("sda level passed the glitch filter on one sample");
  AST_ACK_LEAD: assert property (
    $rose(sda_oe) && $past(ack_slot && remote_active) |-> scl_oe)
    else $error("remote ack bit not led by an scl stretch");
endmodule // ccw_top
`default_nettype wire

// file: ccw_partner.sv
// far side of the local i2c bus: pull-ups, a clocking master and a slave that can hang sda
`default_nettype none
module ccw_partner (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic hang,
  input wire logic scl_run,
  // device pin controls
  input wire logic scl_oe,
  input wire logic sda_oe,
  // wire levels
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low = 1'b0;
  logic [3:0] div = 4'h0;
  // scl stands high outside frames, so the bus looks quiet to the watchdog
  always @(posedge clk) begin
    div <= div + 4'h1;
    if (!scl_run) scl_low <= 1'b0;
    else if (div == 4'hf) scl_low <= !scl_low;
  end
  // open drain with pull-ups: any party pulling low wins
  assign scl_in = !(scl_oe || scl_low);
  assign sda_in = !(sda_oe || hang);
endmodule // ccw_partner
`default_nettype wire

// file: ccw_top_test.sv
// self-checking bench for the control link watchdog and local i2c timing block
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: %h %h", $time, a, b); end end
module ccw_top_test
  import ccw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, link_start, link_done, tx_sda_low, ack_slot, remote_active;
  logic hang, scl_run, seen, reg_rvalid, reg_refused, link_busy, link_abort;
  logic scl_in, sda_in, scl_oe, sda_oe, bus_free, bus_recovering, scl_clean, sda_clean;
  logic [7:0] reg_rdata, v;
  ccw_reg_req_s reg_req;
  int fails = 0, n_compared = 0, n, m;

  ccw_top #(.TMO_UNIT(4), .BUS_SLOW(600)) i_dut (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_refused(reg_refused),
    .link_start(link_start), .link_done(link_done), .link_busy(link_busy),
    .link_abort(link_abort), .tx_sda_low(tx_sda_low), .ack_slot(ack_slot),
    .remote_active(remote_active), .scl_in(scl_in), .sda_in(sda_in), .scl_out(),
    .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .scl_clean(scl_clean),
    .sda_clean(sda_clean),
    .bus_free(bus_free), .bus_recovering(bus_recovering));
  ccw_partner i_far (.clk(clk), .hang(hang), .scl_run(scl_run), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  task automatic stop_test();
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #10;
  endtask

  // bounded wait; a wait that runs out ends the run
  task automatic await(ref logic s, input logic val, input int lim, output int k);
    k = 0;
    while (s !== val && k < lim) begin
      tick();
      k++;
    end
    if (k >= lim) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic strobe(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  // leading tick keeps valid low for an edge between two requests
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_req = '{1'b1, w, r, a, d};
    tick();
    reg_req.valid = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, 1'b0, a, 8'h00);
    `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
  endtask

  task automatic watch(input int k);
    seen = 1'b0;
    repeat (k) begin
      tick();
      seen |= link_abort;
    end
  endtask

  task automatic reset_dut();
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
  endtask

  // cycles that scl is held low ahead of its rise for a remote ack bit
  function automatic int lead_cyc(input int f);
    return (SETUP_BASE_NS + f * SETUP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  // cycles from an scl fall until sda is pulled, with the bus watchdog off
  task automatic sda_lag(input logic [1:0] code, output int k);
    int j;
    acc(1'b1, 1'b0, OUT_CTRL_OFS, {4'h1, code, 2'b01});
    tx_sda_low = 1'b0;
    scl_run = 1'b1;
    repeat (2) begin
      await(scl_in, 1'b0, 100, k);
      await(scl_in, 1'b1, 100, k);
    end
    // last bit is a remote ack, so scl must stay low after sda moves
    {tx_sda_low, ack_slot, remote_active} = 3'b111;
    await(scl_in, 1'b0, 100, k);
    await(sda_oe, 1'b1, 30, k);
    `CHK(scl_oe, 1'b1)
    await(scl_oe, 1'b0, 30, j);
    `CHK(j, lead_cyc(1))
    scl_run = 1'b0;
    {tx_sda_low, ack_slot, remote_active} = 3'b000;
  endtask

  initial begin
    {rst, link_start, link_done, tx_sda_low, ack_slot, remote_active, hang, scl_run} = 8'h80;
    reg_req = '0;
    void'($urandom(32'h124e8b38));
    reset_dut();
    rd(LINK_WDOG_OFS, 8'hfe);
    rd(IN_CTRL_OFS, 8'h1c);
    rd(OUT_CTRL_OFS, 8'h10);
    rd(8'h0a, 8'h00);
    acc(1'b1, 1'b0, OUT_CTRL_OFS, 8'h02);
    await(bus_free, 1'b1, 800, n);
    `CHK(n > 480 && n < 520, 1'b1)
    hang = 1'b1;
    await(bus_recovering, 1'b1, 700, n);
    `CHK({scl_clean, sda_clean}, 2'b10)
    m = 0;
    // count completed low pulses; the first begins together with recovery
    while (bus_recovering === 1'b1 && n < 2000) begin
      v[0] = scl_oe;
      tick();
      n++;
      if (v[0] === 1'b1 && scl_oe === 1'b0) m++;
    end
    `CHK(m, 9)
    `CHK(bus_recovering, 1'b0)
    hang = 1'b0;
    reset_dut();
    acc(1'b1, 1'b0, OUT_CTRL_OFS, 8'h03);
    tick(700);
    `CHK(bus_free, 1'b0)
    acc(1'b1, 1'b0, IN_CTRL_OFS, 8'h9c);
    acc(1'b1, 1'b1, OUT_CTRL_OFS, 8'h55);
    `CHK(reg_refused, 1'b1)
    rd(OUT_CTRL_OFS, 8'h03);
    acc(1'b1, 1'b0, OUT_CTRL_OFS, 8'h0d);
    rd(OUT_CTRL_OFS, 8'h0d);
    acc(1'b1, 1'b0, IN_CTRL_OFS, 8'h1c);
    repeat (4) begin
      v = 8'($urandom) & 8'h7f;
      acc(1'b1, 1'($urandom_range(1)), IN_CTRL_OFS, v);
      `CHK(reg_refused, 1'b0)
      rd(IN_CTRL_OFS, v);
    end
    repeat (3) begin
      v = 8'($urandom_range(1, 8)); // zero is never programmed
      acc(1'b1, 1'b0, LINK_WDOG_OFS, {v[6:0], 1'b0});
      strobe(link_start);
      await(link_abort, 1'b1, 60, n);
      `CHK(n, 4 * v)
      `CHK(link_busy, 1'b0)
    end
    strobe(link_start);
    tick(2);
    `CHK(link_busy, 1'b1)
    strobe(link_done);
    watch(40);
    `CHK({seen, link_busy}, 2'b00)
    acc(1'b1, 1'b0, LINK_WDOG_OFS, 8'h05);
    strobe(link_start);
    watch(40);
    `CHK(seen, 1'b0)
    sda_lag(2'b00, n);
    sda_lag(2'b11, m);
    `CHK(m - n, 1)
    stop_test();
  end
endmodule // ccw_top_test
`default_nettype wire
